// [logic/ddlt_top.sv]
// Load timer channel: APB registers, sequencer and interrupt flag.
`timescale 1ns/10ps
`default_nettype none
`include "ddlt_cfg.svh"

// Functional notes
// [R1] A descending channel counts down from the load value and signals when it reaches zero.
// [R2] An ascending channel counts up from zero and signals when it equals the load value.
// [R3] Writing zero to control bit 0 disables the channel and drops the run-enable output.
// [R4] Control bit 1 picks the mode, here one for one-shot and zero for free-running.
// [R5] Control bit 2 lets the interrupt out when one and masks it when zero.
// [R6] The load value is two read-write words, low half and high half.
// [R7] Software starts the channel by writing one to control bit 0 after both halves.
// [R8] A descending channel loads the load value on enable and on reaching zero when free.
// [R9] An ascending channel clears to zero on enable and on reaching the load value when free.
// [R10] In one-shot mode the count stops at its terminal value until disabled and restarted.
// [R11] In free-running mode the count reloads at its terminal value and goes on.
// [R12] The present count reads back as two read-only words, low and high.
// [R13] Software uses only whole 32-bit word accesses.
// [R14] Counting advances on the 24 MHz oscillator clock.
// [R15] Status bit 0 holds the pending interrupt and a one written there clears it.
// [R16] The count clock runs only while enabled; configuration changes only while disabled.
// [R17] Reaching the terminal value sets the pending bit, which drives the interrupt if unmasked.
module ddlt_top #(
	parameter bit COUNT_UP = 1'b0
) (
	// System.
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	input wire logic CE_IN,
	// APB slave.
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [`DDLT_ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Oscillator clock, run enable and interrupt.
	input wire logic TMR_CLK_IN,
	output logic TMR_EN_OUT,
	output logic IRQ_OUT
);
	import ddlt_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int CW = 64;
	localparam logic [2:0] RST_CTRL = `DDLT_RST_CTRL;

	logic [31:0] load_lo_r, load_lo_nxt, load_hi_r, load_hi_nxt;
	logic en_r, en_nxt, user_mode_r, user_mode_nxt, mask_r, mask_nxt;
	logic pend_r, pend_nxt, irq_r, irq_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	ddlt_state_t state_r, state_nxt;
	ddlt_op_t cnt_op;
	logic [CW-1:0] count;
	logic at_term, step_hit, hit, tick;
	logic setup_ph, wr_acc, addr_ok;

	// ****************************************************************
	// Oscillator tick and count register
	// ****************************************************************

	// The oscillator clock is sampled, not used as a clock, so the design keeps one domain.
	ddlt_sync u_tick (
		.clk_in(CLK_SYS_IN),
		.rst_in(SYS_RST_IN),
		.ce_in(CE_IN),
		.async_in(TMR_CLK_IN), // R14
		.rise_out(tick)
	);

	ddlt_counter #(
		.COUNT_UP(COUNT_UP),
		.W(CW)
	) u_count (
		.clk_in(CLK_SYS_IN),
		.rst_in(SYS_RST_IN),
		.ce_in(CE_IN),
		.op_in(cnt_op),
		.load_in({load_hi_r, load_lo_r}),
		.count_out(count),
		.at_term_out(at_term),
		.step_hit_out(step_hit)
	);

	// ****************************************************************
	// APB decode
	// ****************************************************************

	// Answer data are prepared in the setup phase so that the access phase has no wait.
	assign setup_ph = PSEL_IN && !PENABLE_IN;
	assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && pready_r && !pslverr_r;

	// Only the six word offsets are mapped; anything else answers with an error.
	always_comb begin
		case (PADDR_IN)
			`DDLT_OFS_LOAD_LO,
			`DDLT_OFS_LOAD_HI,
			`DDLT_OFS_COUNT_LO,
			`DDLT_OFS_COUNT_HI,
			`DDLT_OFS_CTRL,
			`DDLT_OFS_PEND: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Read mux and handshake next values.
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		pready_nxt = setup_ph;
		pslverr_nxt = setup_ph && !addr_ok;
		if (setup_ph && !PWRITE_IN) begin
			case (PADDR_IN)
				`DDLT_OFS_LOAD_LO: prdata_nxt = load_lo_r;
				`DDLT_OFS_LOAD_HI: prdata_nxt = load_hi_r;
				`DDLT_OFS_COUNT_LO: prdata_nxt = count[31:0]; // R12
				`DDLT_OFS_COUNT_HI: prdata_nxt = count[63:32]; // R12
				`DDLT_OFS_CTRL: prdata_nxt = {29'h0000_0000, mask_r, user_mode_r, en_r};
				`DDLT_OFS_PEND: prdata_nxt = {31'h0000_0000, pend_r};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Configuration registers and pending flag
	// ****************************************************************

	// Load value and mode bits are locked while enabled, so a running count never sees
	// a half-written value; the enable bit itself is always writable.
	always_comb begin
		load_lo_nxt = load_lo_r;
		load_hi_nxt = load_hi_r;
		en_nxt = en_r;
		user_mode_nxt = user_mode_r;
		mask_nxt = mask_r;
		pend_nxt = pend_r;
		if (wr_acc && !en_r) begin // R16
			if (PADDR_IN == `DDLT_OFS_LOAD_LO) begin
				load_lo_nxt = PWDATA_IN; // R6
			end
			if (PADDR_IN == `DDLT_OFS_LOAD_HI) begin
				load_hi_nxt = PWDATA_IN; // R6
			end
		end
		if (wr_acc && PADDR_IN == `DDLT_OFS_CTRL) begin
			en_nxt = PWDATA_IN[`DDLT_CTRL_EN_BIT]; // R3 R7
			if (!en_r) begin
				user_mode_nxt = PWDATA_IN[`DDLT_CTRL_MODE_BIT]; // R4
				mask_nxt = PWDATA_IN[`DDLT_CTRL_MASK_BIT]; // R5
			end
		end
		if (wr_acc && PADDR_IN == `DDLT_OFS_PEND && PWDATA_IN[`DDLT_PEND_BIT]) begin
			pend_nxt = 1'b0; // R15
		end
		// A terminal event in the clearing cycle is kept: the set wins.
		if (hit) begin
			pend_nxt = 1'b1; // R17
		end
		irq_nxt = pend_nxt && mask_nxt; // R5 R17
	end

	// Registers of the configuration group.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			load_lo_r <= `DDLT_RST_LOAD;
			load_hi_r <= `DDLT_RST_LOAD;
			en_r <= RST_CTRL[`DDLT_CTRL_EN_BIT];
			user_mode_r <= RST_CTRL[`DDLT_CTRL_MODE_BIT];
			mask_r <= RST_CTRL[`DDLT_CTRL_MASK_BIT];
			pend_r <= `DDLT_RST_PEND;
			irq_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (CE_IN) begin
			load_lo_r <= load_lo_nxt;
			load_hi_r <= load_hi_nxt;
			en_r <= en_nxt;
			user_mode_r <= user_mode_nxt;
			mask_r <= mask_nxt;
			pend_r <= pend_nxt;
			irq_r <= irq_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ****************************************************************
	// Channel sequencer
	// ****************************************************************

	// A channel that starts on its terminal value reloads or halts without an event;
	// events come only from a step that lands on the terminal value.
	always_comb begin
		state_nxt = state_r;
		cnt_op = OP_HOLD;
		hit = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (en_r) begin
					cnt_op = OP_LOAD; // R8 R9
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!en_r) begin
					state_nxt = ST_IDLE; // R3
				end else if (tick) begin // R16
					if (at_term) begin
						if (user_mode_r) begin
							state_nxt = ST_HALT; // R10
						end else begin
							cnt_op = OP_LOAD; // R11 R8 R9
						end
					end else begin
						cnt_op = OP_STEP; // R1 R2
						hit = step_hit; // R1 R2
						if (step_hit && user_mode_r) begin
							state_nxt = ST_HALT; // R10
						end
					end
				end
			end
			ST_HALT: begin
				if (!en_r) begin
					state_nxt = ST_IDLE; // R10
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			state_r <= ST_IDLE;
		end else if (CE_IN) begin
			state_r <= state_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign PRDATA_OUT = prdata_r;
	assign PREADY_OUT = pready_r;
	assign PSLVERR_OUT = pslverr_r;
	assign TMR_EN_OUT = en_r; // R3 R16
	assign IRQ_OUT = irq_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (SYS_RST_IN);

	sequence s_ctrl_wr;
		CE_IN && wr_acc && PADDR_IN == `DDLT_OFS_CTRL;
	endsequence

	sequence s_step;
		CE_IN && state_r == ST_RUN && en_r && tick && !at_term;
	endsequence

	sequence s_reload;
		CE_IN && state_r == ST_RUN && en_r && tick && at_term && !user_mode_r;
	endsequence

	a_disable_drops_en: assert property ( // R3
		s_ctrl_wr ##0 !PWDATA_IN[`DDLT_CTRL_EN_BIT] |=> !TMR_EN_OUT)
		else $error("run enable still high after disable write");

	a_start_loads: assert property ( // R8 R9
		CE_IN && state_r == ST_IDLE && en_r
		|=> state_r == ST_RUN && count == (COUNT_UP ? '0 : $past({load_hi_r, load_lo_r})))
		else $error("count not loaded on enable");

	a_step_dir: assert property ( // R1 R2
		s_step |=> (COUNT_UP ? count == $past(count) + 64'h1 : count == $past(count) - 64'h1))
		else $error("count did not step in its direction");

	a_free_reload: assert property ( // R11
		s_reload |=> count == (COUNT_UP ? '0 : $past({load_hi_r, load_lo_r})))
		else $error("free-running count did not reload");

	a_user_holds: assert property ( // R10
		CE_IN && state_r == ST_HALT && en_r |=> count == $past(count) && state_r == ST_HALT)
		else $error("halted count moved");

	a_hit_sets_pend: assert property ( // R17
		s_step ##0 step_hit |=> pend_r && IRQ_OUT == mask_r)
		else $error("terminal step did not set pending");

	a_w1c_clears: assert property ( // R15
		CE_IN && wr_acc && PADDR_IN == `DDLT_OFS_PEND && PWDATA_IN[0] && !hit |=> !pend_r)
		else $error("write one did not clear pending");

	a_mask_blocks: assert property ( // R5
		!mask_r && !(CE_IN && wr_acc) |=> !IRQ_OUT)
		else $error("interrupt out while masked");

	a_read_count: assert property ( // R12
		CE_IN && setup_ph && !PWRITE_IN && PADDR_IN == `DDLT_OFS_COUNT_LO
		|=> PREADY_OUT && PRDATA_OUT == $past(count[31:0]))
		else $error("count low half read wrong");

	a_load_locked: assert property ( // R16 R6
		en_r && CE_IN |=> load_lo_r == $past(load_lo_r) && load_hi_r == $past(load_hi_r))
		else $error("load value changed while enabled");

endmodule

`default_nettype wire

// [include/ddlt_cfg.svh]
// Register offsets, field positions and reset values of the load timer channel.
`ifndef DDLT_CFG_SVH
`define DDLT_CFG_SVH

// ****************************************************************
// Register map (byte offsets on the APB port)
// ****************************************************************
`define DDLT_ADDR_W 8
`define DDLT_OFS_LOAD_LO 8'h00
`define DDLT_OFS_LOAD_HI 8'h04
`define DDLT_OFS_COUNT_LO 8'h08
`define DDLT_OFS_COUNT_HI 8'h0c
`define DDLT_OFS_CTRL 8'h10
`define DDLT_OFS_PEND 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define DDLT_CTRL_EN_BIT 0
`define DDLT_CTRL_MODE_BIT 1
`define DDLT_CTRL_MASK_BIT 2
`define DDLT_PEND_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define DDLT_RST_LOAD 32'h0000_0000
`define DDLT_RST_CTRL 3'h0
`define DDLT_RST_PEND 1'b0
`define DDLT_RST_COUNT 64'h0000_0000_0000_0000

`endif

// [include/ddlt_pkg.sv]
// Types shared by the load timer channel.
package ddlt_pkg;

	// Channel sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN = 3'h2,
		ST_HALT = 3'h4
	} ddlt_state_t;

	// Operation applied to the count register in one cycle.
	typedef enum logic [1:0] {
		OP_HOLD = 2'h0,
		OP_LOAD = 2'h1,
		OP_STEP = 2'h2
	} ddlt_op_t;

endpackage

// [logic/ddlt_sync.sv]
// Two-stage synchroniser with rising-edge detect for the oscillator clock.
`timescale 1ns/10ps
`default_nettype none

module ddlt_sync (
	// System.
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Asynchronous level in, one-cycle pulse out.
	input wire logic async_in,
	output logic rise_out
);
	logic s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;

	// The first stage feeds only the second; the edge is taken from stages two and three.
	always_comb begin
		s1_nxt = async_in;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	// Registers, frozen while the clock enable is low.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else if (ce_in) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	// One pulse per oscillator period.
	assign rise_out = s2_r && !s3_r;

endmodule

`default_nettype wire

// [logic/ddlt_counter.sv]
// Sixty-four-bit count register that loads, steps up or down, and compares.
`timescale 1ns/10ps
`default_nettype none
`include "ddlt_cfg.svh"

module ddlt_counter #(
	parameter bit COUNT_UP = 1'b0,
	parameter int W = 64
) (
	// System.
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Control and load value.
	input wire ddlt_pkg::ddlt_op_t op_in,
	input wire logic [W-1:0] load_in,
	// Count and compare results.
	output logic [W-1:0] count_out,
	output logic at_term_out,
	output logic step_hit_out
);
	import ddlt_pkg::*;

	localparam logic [W-1:0] ONE = 1;
	logic [W-1:0] count_r, count_nxt, start_val, term_val, step_val;

	// Direction fixes both the start value and the terminal value.
	always_comb begin
		start_val = COUNT_UP ? '0 : load_in;
		term_val = COUNT_UP ? load_in : '0;
		step_val = COUNT_UP ? count_r + ONE : count_r - ONE;
		case (op_in)
			OP_LOAD: count_nxt = start_val;
			OP_STEP: count_nxt = step_val;
			default: count_nxt = count_r;
		endcase
	end

	// Count register.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_r <= W'(`DDLT_RST_COUNT);
		end else if (ce_in) begin
			count_r <= count_nxt;
		end
	end

	assign count_out = count_r;
	assign at_term_out = (count_r == term_val);
	assign step_hit_out = (step_val == term_val);

endmodule

`default_nettype wire

// [verification/ddlt_top_tb.sv]
// Self-checking bench for the load timer channel, both count directions side by side.
`timescale 1ns/10ps
`default_nettype none

module ddlt_top_tb;
	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic clk, rst, psel, pen, pwr, tclk, ce;
	logic [7:0] paddr;
	logic [31:0] pwdata, d, u;
	wire logic [31:0] rdata [2];
	wire logic [1:0] rdy, serr, ten, irq;
	logic [1:0] last_err;
	int err_count, num_checks, cycles;

	// Index 0 is the descending channel, index 1 the ascending one; both see the same bus.
	for (genvar g = 0; g < 2; g++) begin : dir
		ddlt_top #(.COUNT_UP(g == 1)) ddlt_top_i (
			.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce),
			.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
			.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(rdata[g]),
			.PREADY_OUT(rdy[g]), .PSLVERR_OUT(serr[g]),
			.TMR_CLK_IN(tclk), .TMR_EN_OUT(ten[g]), .IRQ_OUT(irq[g])
		);
	end

	// System clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cycle ceiling so that a run that never finishes still reaches the report.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			$display("ERROR timeout expected 0 seen 1");
			end_of_test();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One zero-wait transfer; request held for one access cycle, where ready is checked high and not waited for.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		#1;
		psel = 1'b1;
		pen = 1'b0;
		pwr = w;
		paddr = a;
		pwdata = wd;
		@(posedge clk);
		#1;
		pen = 1'b1;
		chk("ready", 2'b11, rdy);
		d = rdata[0];
		u = rdata[1];
		last_err = serr;
		@(posedge clk);
		#1;
		psel = 1'b0;
		pen = 1'b0;
		chk("ready drop", 2'b00, rdy);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic rd2(input string nm, input logic [7:0] a, input logic [31:0] edn,
			input logic [31:0] eup);
		apb(1'b0, a, 32'h0000_0000);
		chk({nm, " down"}, edn, d);
		chk({nm, " up"}, eup, u);
	endtask

	// Oscillator edges, kept slower than the real rate to give the synchroniser margin.
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			tclk = 1'b1;
			repeat (4) @(posedge clk);
			#1;
			tclk = 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{tclk, psel, pen, pwr, paddr, pwdata} = '0;
		ce = 1'b1;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		// Reset values, and the gap at 0x14 answers with a slave error.
		for (int i = 0; i < 7; i++) begin
			if (i != 5) rd2("reset value", 8'(i * 4), 32'h0, 32'h0);
		end
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 2'b11, last_err);
		chk("run enable idle", 2'b00, ten);
		// Free-running, interrupt masked, load value 3.
		wr(8'h00, 32'h3);
		wr(8'h04, 32'h0);
		rd2("load low", 8'h00, 32'h3, 32'h3);
		wr(8'h10, 32'h1);
		chk("run enable on", 2'b11, ten);
		repeat (2) @(posedge clk);
		rd2("count start", 8'h08, 32'h3, 32'h0);
		tick(2);
		rd2("count step", 8'h08, 32'h1, 32'h2);
		rd2("pending early", 8'h18, 32'h0, 32'h0);
		tick(1);
		rd2("count terminal", 8'h08, 32'h0, 32'h3);
		rd2("pending set", 8'h18, 32'h1, 32'h1);
		chk("irq masked", 2'b00, irq);
		tick(1);
		rd2("count reload", 8'h08, 32'h3, 32'h0);
		wr(8'h18, 32'h0);
		rd2("pending kept", 8'h18, 32'h1, 32'h1);
		wr(8'h18, 32'h1);
		rd2("pending cleared", 8'h18, 32'h0, 32'h0);
		// Writes while running to the load word and to the count word change nothing.
		wr(8'h00, 32'h9);
		rd2("load locked", 8'h00, 32'h3, 32'h3);
		wr(8'h08, 32'h5);
		rd2("count read only", 8'h08, 32'h3, 32'h0);
		// One-shot, unmasked, load value 2.
		wr(8'h10, 32'h0);
		chk("run enable off", 2'b00, ten);
		wr(8'h10, 32'h6);
		wr(8'h00, 32'h2);
		wr(8'h10, 32'h7);
		rd2("control", 8'h10, 32'h7, 32'h7);
		rd2("count restart", 8'h08, 32'h2, 32'h0);
		tick(2);
		rd2("count oneshot end", 8'h08, 32'h0, 32'h2);
		chk("irq raised", 2'b11, irq);
		tick(2);
		rd2("count halted", 8'h08, 32'h0, 32'h2);
		wr(8'h18, 32'h1);
		chk("irq cleared", 2'b00, irq);
		// Upper half of the count: descending borrow across the word boundary.
		wr(8'h10, 32'h4);
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h5);
		rd2("count high start", 8'h0c, 32'h1, 32'h0);
		tick(1);
		rd2("count low borrow", 8'h08, 32'hffff_ffff, 32'h1);
		rd2("count high borrow", 8'h0c, 32'h0, 32'h0);
		// Clock enable low freezes the synchroniser and the count through a whole tick.
		ce = 1'b0;
		tick(1);
		#1;
		ce = 1'b1;
		rd2("count frozen", 8'h08, 32'hffff_ffff, 32'h1);
		end_of_test();
	end
endmodule

`default_nettype wire
